/* rtl/tcd_pkg.sv */
/*
 * package for the tape centerdrive control block: timing constants,
 * reset values and the packed carriers shared by the design files.
 * assumes a single 125 MHz clock and synchronous active-high reset.
 */
package tcd_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_MHZ = 125;
  // start pulse width, in nanoseconds
  localparam int unsigned START_PULSE_NS = 500;
  localparam int unsigned START_PULSE_CYC =
    (START_PULSE_NS * CLK_MHZ) / 1000;
  // delay before pickup done, in milliseconds
  localparam int unsigned PICKUP_DELAY_MS = 10;
  localparam int unsigned PICKUP_DELAY_CYC =
    PICKUP_DELAY_MS * CLK_MHZ * 1000;
  // clear relay energize time, in milliseconds
  localparam int unsigned CLEAR_RELAY_MS = 10;
  localparam int unsigned CLEAR_RELAY_CYC =
    CLEAR_RELAY_MS * CLK_MHZ * 1000;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned PULSE_W = 8;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic INTERLOCK_RST = 1'h1;
  localparam logic DRIVE_RST = 1'h0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic read_fwd;
    logic read_bwd;
    logic write_fwd;
    logic no_ring_indication;
  } tcd_unit_status_s;

  typedef struct packed {
    logic read_preset_pulse;
    logic write_preset_pulse;
    logic rw_control_reset_pulse;
    logic clear_out_buffer;
  } tcd_preset_s;

  typedef struct packed {
    logic read_start_pulse;
    logic write_start_pulse;
    logic direction_error_pulse;
  } tcd_start_s;

endpackage : tcd_pkg

/* rtl/tcd_centerdrive.sv */
/*
 * tape centerdrive control: interlocks, presets, start and drive
 * flip-flops, direction check and clear relay timing.
 * assumes: unit status lines arrive from the tape unit asynchronously
 * and are synchronised here; all other inputs are single-cycle pulses
 * or levels on mclk from neighbouring logic.
 */
// Summary of operation
// RULE1: read and write drives are independent flip-flops, may run together.
// RULE2: unit selection preset sets both read and write interlocks.
// RULE3: set interlock blocks drive; clear one opens drive and error gates.
// RULE4: pickup done, read op, read drive idle gives a read preset pulse.
// RULE5: read preset clears read circuits and resets the read interlock.
// RULE6: write preset needs pickup done, write op, write drive idle, no ring.
// RULE7: write preset clears buffer, write circuits, resets write interlock.
// RULE8: no-ring indication sets ring flag, which keeps write interlock set.
// RULE9: read and write presets merge into one control reset pulse.
// RULE10: program waits for selection done, plus 0.8 s on reversal.
// RULE11: start strobe sets start-tape only when unit is available.
// RULE12: start set, direction right: read or write start by clear interlock.
// RULE13: start set, direction wrong: direction error to diag and unit error.
// RULE14: read direction compares unit read fwd/bwd with read-direction ffs.
// RULE15: write valid only forward, judged from write-forward line alone.
// RULE16: start pulse sets drive, clears start-tape, tells rw circuits.
// RULE17: drive output fed back to end start pulse after 0.5 us.
// RULE18: drive holds for the operation; ending signal clears it.
// RULE19: ending signal times a clear relay output to drop thyratrons.
// RULE20: pickup done comes 10 ms after selection end is detected.
// RULE21: direction error clears start-tape so a later start can retry.
`timescale 1ns/100ps
module tcd_centerdrive #(
  parameter int unsigned PICKUP_CYC = tcd_pkg::PICKUP_DELAY_CYC,
  parameter int unsigned RELAY_CYC = tcd_pkg::CLEAR_RELAY_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic select_preset,
  input wire logic selection_end,
  input wire logic op_read,
  input wire logic op_write,
  input wire logic unit_available,
  input wire logic start_instruction_strobe,
  input wire logic read_dir_fwd,
  input wire logic read_dir_bwd,
  input wire tcd_pkg::tcd_unit_status_s unit_status,
  input wire logic read_ending,
  input wire logic write_ending,
  output tcd_pkg::tcd_preset_s preset,
  output tcd_pkg::tcd_start_s start,
  output logic pickup_done_pulse,
  output logic read_drive,
  output logic write_drive,
  output logic read_clear_relay,
  output logic write_clear_relay,
  output logic unit_control_error,
  output logic direction_diag
);

  // ************************************************************
  // synchronisers for tape unit status
  // ************************************************************
  tcd_pkg::tcd_unit_status_s stat_meta_ff;
  tcd_pkg::tcd_unit_status_s stat_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stat_meta_ff <= '0;
      stat_ff <= '0;
    end
    else
    begin
      stat_meta_ff <= unit_status;
      stat_ff <= stat_meta_ff;
    end
  end

  // ************************************************************
  // pickup ending delay
  // ************************************************************
  logic [tcd_pkg::CNT_W-1:0] pick_cnt_ff;
  logic pick_run_ff;
  logic pickup_done_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pick_cnt_ff <= '0;
      pick_run_ff <= 1'h0;
      pickup_done_ff <= 1'h0;
    end
    else
    begin
      pickup_done_ff <= 1'h0;
      if (selection_end)
      begin
        pick_run_ff <= 1'h1; // see RULE20
        pick_cnt_ff <= tcd_pkg::CNT_W'(PICKUP_CYC - 1);
      end
      else if (pick_run_ff)
      begin
        if (pick_cnt_ff == '0)
        begin
          pick_run_ff <= 1'h0;
          pickup_done_ff <= 1'h1; // see RULE20
        end
        else
        begin
          pick_cnt_ff <= pick_cnt_ff - 1'h1;
        end
      end
    end
  end

  // ************************************************************
  // presets, ring flag and interlocks
  // ************************************************************
  logic rd_ilk_ff;
  logic wr_ilk_ff;
  logic ring_ff;
  logic rd_drv_ff;
  logic wr_drv_ff;
  logic nxt_rd_pre;
  logic nxt_wr_pre;
  tcd_pkg::tcd_preset_s preset_ff;

  // separate read and write paths run concurrently
  assign nxt_rd_pre = pickup_done_ff & op_read & ~rd_drv_ff; // see RULE4
  assign nxt_wr_pre = pickup_done_ff & op_write & ~wr_drv_ff
                      & ~ring_ff; // see RULE6

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      preset_ff <= '0;
    end
    else
    begin
      preset_ff.read_preset_pulse <= nxt_rd_pre;
      preset_ff.write_preset_pulse <= nxt_wr_pre;
      preset_ff.clear_out_buffer <= nxt_wr_pre; // see RULE7
      preset_ff.rw_control_reset_pulse <= nxt_rd_pre
                                         | nxt_wr_pre; // see RULE9
    end
  end

  // ring flag cleared only by a new selection
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ring_ff <= 1'h0;
    end
    else if (stat_ff.no_ring_indication)
    begin
      ring_ff <= 1'h1; // see RULE8
    end
    else if (select_preset)
    begin
      ring_ff <= 1'h0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_ilk_ff <= tcd_pkg::INTERLOCK_RST;
      wr_ilk_ff <= tcd_pkg::INTERLOCK_RST;
    end
    else
    begin
      if (select_preset)
      begin
        rd_ilk_ff <= 1'h1; // see RULE2
        wr_ilk_ff <= 1'h1; // see RULE2
      end
      else
      begin
        if (nxt_rd_pre)
        begin
          rd_ilk_ff <= 1'h0; // see RULE5
        end
        if (ring_ff)
        begin
          wr_ilk_ff <= 1'h1; // see RULE8
        end
        else if (nxt_wr_pre)
        begin
          wr_ilk_ff <= 1'h0; // see RULE7
        end
      end
    end
  end

  // ************************************************************
  // start-tape, direction check and start pulses
  // ************************************************************
  logic start_tape_ff;
  logic rd_dir_ok;
  logic wr_dir_ok;
  logic rd_go;
  logic wr_go;
  logic dir_err;
  tcd_pkg::tcd_start_s start_ff;

  assign rd_dir_ok = (stat_ff.read_fwd & read_dir_fwd)
                   | (stat_ff.read_bwd & read_dir_bwd); // see RULE14
  assign wr_dir_ok = stat_ff.write_fwd; // see RULE15
  // a cleared interlock opens the drive gate and the error gate
  assign rd_go = start_tape_ff & ~rd_ilk_ff & ~rd_drv_ff
                 & rd_dir_ok; // see RULE3
  assign wr_go = start_tape_ff & ~wr_ilk_ff & ~wr_drv_ff
                 & wr_dir_ok; // see RULE3
  assign dir_err = start_tape_ff
                   & ((~rd_ilk_ff & ~rd_drv_ff & ~rd_dir_ok)
                   | (~wr_ilk_ff & ~wr_drv_ff & ~wr_dir_ok)); // see RULE13

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      start_tape_ff <= 1'h0;
    end
    else if (start_instruction_strobe & unit_available)
    begin
      start_tape_ff <= 1'h1; // see RULE11
    end
    else if (rd_go | wr_go)
    begin
      start_tape_ff <= 1'h0; // see RULE16
    end
    else if (dir_err)
    begin
      start_tape_ff <= 1'h0; // see RULE21
    end
  end

  // pulses stretch over the drive feedback window, then end
  logic [tcd_pkg::PULSE_W-1:0] rd_pw_ff;
  logic [tcd_pkg::PULSE_W-1:0] wr_pw_ff;
  localparam logic [tcd_pkg::PULSE_W-1:0] PW_LOAD =
    tcd_pkg::PULSE_W'(tcd_pkg::START_PULSE_CYC - 1);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_pw_ff <= '0;
      wr_pw_ff <= '0;
      start_ff <= '0;
    end
    else
    begin
      start_ff.direction_error_pulse <= dir_err; // see RULE13
      if (rd_go)
      begin
        rd_pw_ff <= PW_LOAD;
        start_ff.read_start_pulse <= 1'h1; // see RULE12
      end
      else if (rd_pw_ff != '0)
      begin
        rd_pw_ff <= rd_pw_ff - 1'h1;
      end
      else
      begin
        start_ff.read_start_pulse <= 1'h0; // see RULE17
      end
      if (wr_go)
      begin
        wr_pw_ff <= PW_LOAD;
        start_ff.write_start_pulse <= 1'h1; // see RULE12
      end
      else if (wr_pw_ff != '0)
      begin
        wr_pw_ff <= wr_pw_ff - 1'h1;
      end
      else
      begin
        start_ff.write_start_pulse <= 1'h0; // see RULE17
      end
    end
  end

  // ************************************************************
  // drive flip-flops, error flags and clear relays
  // ************************************************************
  // drive set wins over an ending in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_drv_ff <= tcd_pkg::DRIVE_RST;
      wr_drv_ff <= tcd_pkg::DRIVE_RST;
    end
    else
    begin
      if (rd_go)
      begin
        rd_drv_ff <= 1'h1; // see RULE16
      end
      else if (read_ending)
      begin
        rd_drv_ff <= 1'h0; // see RULE18
      end
      if (wr_go)
      begin
        wr_drv_ff <= 1'h1; // see RULE1
      end
      else if (write_ending)
      begin
        wr_drv_ff <= 1'h0; // see RULE18
      end
    end
  end

  // error flags are cleared by a new selection; new error wins
  logic unit_err_ff;
  logic diag_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      unit_err_ff <= 1'h0;
      diag_ff <= 1'h0;
    end
    else if (dir_err)
    begin
      unit_err_ff <= 1'h1; // see RULE13
      diag_ff <= 1'h1; // see RULE13
    end
    else if (select_preset)
    begin
      unit_err_ff <= 1'h0;
      diag_ff <= 1'h0;
    end
  end

  logic [tcd_pkg::CNT_W-1:0] rrel_cnt_ff;
  logic [tcd_pkg::CNT_W-1:0] wrel_cnt_ff;
  logic rrel_ff;
  logic wrel_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rrel_cnt_ff <= '0;
      wrel_cnt_ff <= '0;
      rrel_ff <= 1'h0;
      wrel_ff <= 1'h0;
    end
    else
    begin
      if (read_ending)
      begin
        rrel_cnt_ff <= tcd_pkg::CNT_W'(RELAY_CYC - 1); // see RULE19
        rrel_ff <= 1'h1;
      end
      else if (rrel_cnt_ff != '0)
      begin
        rrel_cnt_ff <= rrel_cnt_ff - 1'h1;
      end
      else
      begin
        rrel_ff <= 1'h0;
      end
      if (write_ending)
      begin
        wrel_cnt_ff <= tcd_pkg::CNT_W'(RELAY_CYC - 1); // see RULE19
        wrel_ff <= 1'h1;
      end
      else if (wrel_cnt_ff != '0)
      begin
        wrel_cnt_ff <= wrel_cnt_ff - 1'h1;
      end
      else
      begin
        wrel_ff <= 1'h0;
      end
    end
  end

  assign preset = preset_ff;
  assign start = start_ff;
  assign pickup_done_pulse = pickup_done_ff;
  assign read_drive = rd_drv_ff;
  assign write_drive = wr_drv_ff;
  assign read_clear_relay = rrel_ff;
  assign write_clear_relay = wrel_ff;
  assign unit_control_error = unit_err_ff;
  assign direction_diag = diag_ff;

endmodule : tcd_centerdrive

/* dv/tcd_tape_unit.sv */
/* tape unit model: returns direction and ring status lines.
   assumes the bench sets the unit's knobs between operations. */
`timescale 1ns/100ps
module tcd_tape_unit (
  input wire logic mclk,
  input wire logic [3:0] knob,
  output tcd_pkg::tcd_unit_status_s unit_status
);
  // *****
  // status lines
  // *****
  // relay contacts settle late, so status lags the knobs by one cycle
  always_ff @(posedge mclk)
  begin
    unit_status <= tcd_pkg::tcd_unit_status_s'(knob);
  end
endmodule : tcd_tape_unit

/* dv/tcd_props.sv */
/* checker for the centerdrive control ports.
   assumes binding onto tcd_centerdrive, one clock domain. */
`timescale 1ns/100ps
module tcd_props #(
  parameter int unsigned PICKUP_CYC = 20,
  parameter int unsigned RELAY_CYC = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic op_read,
  input wire logic op_write,
  input wire logic read_ending,
  input wire tcd_pkg::tcd_preset_s preset,
  input wire tcd_pkg::tcd_start_s start,
  input wire logic pickup_done_pulse,
  input wire logic read_drive,
  input wire logic write_drive,
  input wire logic read_clear_relay,
  input wire logic unit_control_error,
  input wire logic direction_diag
);
  // *****
  // properties
  // *****
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  rd_preset_a: assert property (pickup_done_pulse && op_read &&
    !read_drive |=> preset.read_preset_pulse) else $error("rd preset");
  wr_preset_a: assert property (preset.write_preset_pulse |->
    $past(pickup_done_pulse) && $past(op_write) && !$past(write_drive))
    else $error("wr preset");
  rs_merge_a: assert property (preset.rw_control_reset_pulse ==
    (preset.read_preset_pulse | preset.write_preset_pulse))
    else $error("rs merge");
  buf_clear_a: assert property (preset.clear_out_buffer ==
    preset.write_preset_pulse) else $error("buf clear");
  start_width_a: assert property ($rose(start.read_start_pulse)
    |-> ##61 start.read_start_pulse ##1 !start.read_start_pulse)
    else $error("start width");
  drive_set_a: assert property ($rose(start.read_start_pulse) |->
    read_drive) else $error("drive set");
  drive_hold_a: assert property (read_drive && !read_ending |=>
    read_drive) else $error("drive hold");
  relay_on_a: assert property (read_ending |=> read_clear_relay)
    else $error("relay on");
  dir_err_a: assert property (start.direction_error_pulse |->
    unit_control_error && direction_diag) else $error("dir err");
endmodule : tcd_props

bind tcd_centerdrive tcd_props #(.PICKUP_CYC(PICKUP_CYC),
  .RELAY_CYC(RELAY_CYC)) u_tcd_props (.mclk, .rst, .op_read, .op_write,
  .read_ending, .preset, .start, .pickup_done_pulse, .read_drive,
  .write_drive, .read_clear_relay, .unit_control_error, .direction_diag);

/* dv/tcd_centerdrive_tb.sv */
/* self-checking bench for the centerdrive control block.
   assumes the tape unit model and the bound checker. */
`timescale 1ns/100ps
module tcd_centerdrive_tb;
  // *****
  // signals
  // *****
  localparam int unsigned PCYC = 20;
  logic mclk = 0, rst = 1, select_preset = 0, selection_end = 0;
  logic op_read = 0, op_write = 0, unit_available = 0;
  logic start_instruction_strobe = 0, read_dir_fwd = 0, read_dir_bwd = 0;
  logic read_ending = 0, write_ending = 0, pickup_done_pulse;
  logic read_drive, write_drive, read_clear_relay, write_clear_relay;
  logic unit_control_error, direction_diag;
  logic [3:0] knob = 0;
  tcd_pkg::tcd_unit_status_s unit_status;
  tcd_pkg::tcd_preset_s preset;
  tcd_pkg::tcd_start_s start;
  int num_errors = 0, checks = 0, cyc = 0;
  tcd_centerdrive #(.PICKUP_CYC(PCYC), .RELAY_CYC(PCYC)) u_tcd_centerdrive (
    .mclk, .rst, .select_preset, .selection_end, .op_read, .op_write,
    .unit_available, .start_instruction_strobe, .read_dir_fwd,
    .read_dir_bwd, .unit_status, .read_ending, .write_ending, .preset,
    .start, .pickup_done_pulse, .read_drive, .write_drive,
    .read_clear_relay, .write_clear_relay, .unit_control_error,
    .direction_diag);
  tcd_tape_unit u_tcd_tape_unit (.mclk, .knob, .unit_status);
  always #4 mclk = ~mclk;
  // a hang ends the run through the same verdict
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  // *****
  // helpers
  // *****
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pick(input logic [3:0] exp);
    int n = 0;
    select_preset = 1;
    tick(1);
    select_preset = 0;
    selection_end = 1;
    tick(1);
    selection_end = 0;
    while (pickup_done_pulse !== 1'h1 && n < 60)
    begin
      tick(1);
      n++;
    end
    tick(1);
    chk({4'h0, preset}, {4'h0, exp});
  endtask : pick
  task automatic go(input logic [2:0] exp);
    start_instruction_strobe = 1;
    tick(1);
    start_instruction_strobe = 0;
    tick(1);
    chk({5'h0, start}, {5'h0, exp});
  endtask : go
  task automatic fin(input logic wr, input logic [3:0] exp);
    // one idle edge so back-to-back calls never reassign an ending
    tick(1);
    read_ending = !wr;
    write_ending = wr;
    tick(1);
    read_ending = 0;
    write_ending = 0;
    chk({4'h0, read_drive, write_drive, read_clear_relay,
      write_clear_relay}, {4'h0, exp});
  endtask : fin
  // *****
  // scenarios
  // *****
  task automatic t_lock();
    op_read = 1;
    read_dir_fwd = 1;
    knob = 4'h8;
    select_preset = 1;
    tick(1);
    select_preset = 0;
    tick(4);
    go(3'h0);
    // start-tape is left pending behind the interlock; a mid-run reset
    // drops it so later scenarios start clean
    rst = 1;
    tick(2);
    rst = 0;
    chk({1'h0, preset, start}, 8'h00);
    chk({4'h0, read_drive, write_drive, read_clear_relay,
      write_clear_relay}, 8'h00);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_read();
    pick(4'hA);
    unit_available = 0;
    go(3'h0);
    unit_available = 1;
    go(3'h4);
    tick(62);
    chk({4'h0, start, read_drive}, 8'h01);
    $display("t_read done");
  endtask : t_read
  task automatic t_both();
    op_write = 1;
    knob = 4'hA;
    tick(3);
    pick(4'h7);
    go(3'h2);
    chk({6'h0, read_drive, write_drive}, 8'h03);
    tick(70);
    fin(1, 4'h9);
    fin(0, 4'h3);
    tick(PCYC + 5);
    fin(1, 4'h1);
    tick(PCYC + 5);
    $display("t_both done");
  endtask : t_both
  task automatic t_dir();
    op_read = 0;
    knob = 4'h8;
    tick(3);
    pick(4'h7);
    go(3'h1);
    chk({6'h0, unit_control_error, direction_diag}, 8'h03);
    knob = 4'h2;
    tick(4);
    chk({4'h0, start, write_drive}, 8'h00);
    go(3'h2);
    tick(70);
    fin(1, 4'h1);
    tick(PCYC + 5);
    $display("t_dir done");
  endtask : t_dir
  task automatic t_ring();
    knob = 4'h3;
    tick(4);
    pick(4'h0);
    go(3'h0);
    $display("t_ring done");
  endtask : t_ring
  task automatic t_rdir();
    op_read = 1;
    op_write = 0;
    read_dir_fwd = 0;
    read_dir_bwd = 1;
    knob = 4'h8;
    tick(4);
    pick(4'hA);
    go(3'h1);
    knob = 4'h4;
    tick(4);
    go(3'h4);
    tick(70);
    fin(0, 4'h2);
    $display("t_rdir done");
  endtask : t_rdir
  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial
  begin
    tick(2);
    rst = 0;
    unit_available = 1;
    chk({1'h0, preset, start}, 8'h00);
    t_lock();
    t_read();
    t_both();
    t_dir();
    t_ring();
    t_rdir();
    end_of_test();
  end
endmodule : tcd_centerdrive_tb
